// File: mcr_defines.svh
// constants for the motor controller status and configuration registers
`ifndef MCR_DEFINES_SVH
`define MCR_DEFINES_SVH
// read and write command codes
`define MCR_RD_STATUS 7'h30
`define MCR_RD_LOCK 7'h31
`define MCR_RD_SAVE_A 7'h32
`define MCR_RD_SAVE_B 7'h33
`define MCR_RD_CFG_A 7'h34
`define MCR_RD_CFG_B 7'h35
`define MCR_WR_SPEED 7'h40
`define MCR_WR_LOCK 7'h71
`define MCR_WR_SAVE_A 7'h72
`define MCR_WR_SAVE_B 7'h73
`define MCR_WR_CFG_A 7'h74
`define MCR_WR_CFG_B 7'h75
// framing
`define MCR_ADDR_FLAG 8'h80
`define MCR_LOW7 8'h7F
// status fields
`define MCR_ST_REV 10
`define MCR_ST_FWD 9
`define MCR_ST_REVERSE_PIN_LEVEL 8
`define MCR_ST_FORWARD_PIN_LEVEL 7
`define MCR_ST_BPIN 6
`define MCR_ST_DT 4
`define MCR_ST_OT 2
`define MCR_ST_OV 1
`define MCR_ST_UV 0
// config a fields
`define MCR_CA_REV 10
`define MCR_CA_FWD 9
`define MCR_CA_DM 4
`define MCR_CA_BM 3
`define MCR_CA_SRC_HI 2
`define MCR_CA_SRC_LO 1
`define MCR_CA_UC 0
// writable masks
`define MCR_LOCK_MASK 14'h000F
`define MCR_SAVE_A_MASK 14'h3BFD
`define MCR_SAVE_B_MASK 14'h001F
`define MCR_CFG_A_MASK 14'h061F
`define MCR_CFG_B_MASK 14'h01C6
`define MCR_ZERO14 14'h0000
// timeouts in ms, cycles at 100 MHz
`define MCR_CLK_HZ 100000000
`define MCR_TO1_MS 50
`define MCR_TO2_MS 500
`define MCR_TO3_MS 2800
`define MCR_CYC_PER_MS (`MCR_CLK_HZ / 1000)
`define MCR_TO1_CYC (`MCR_TO1_MS * `MCR_CYC_PER_MS)
`define MCR_TO2_CYC (`MCR_TO2_MS * `MCR_CYC_PER_MS)
`define MCR_TO3_CYC (`MCR_TO3_MS * `MCR_CYC_PER_MS)
`define MCR_FLASH_CYC 1000
`endif

// File: mcr_pkg.sv
// types for the motor controller register bank
package mcr_pkg;
    typedef enum logic [2:0] {
        MCR_IDLE, MCR_CMD, MCR_D1, MCR_D2, MCR_CHK, MCR_TX1, MCR_TX2, MCR_TX3
    } mcr_state_type;
endpackage

// File: mcr_regs.sv
// byte-level command decoder and register bank of the motor controller
//
// Overview of operation
// - read 0x30 returns status word
// - status bit10 reverse, bit9 forward, none stop
// - status bit4 drive zero, brake one
// - bit1 supply over max, bit0 under min
// - status bit2 shows over temperature
// - locked item ignores pot, serial only
// - lock bits speed, current, regen, accel
// - lock codes 0x71/0x31, cleared on restart
// - save word a only marks, no flash
// - save word a bit layout as listed
// - saved items reload and become locked
// - save word b marks and starts save
// - during save pwm halts, commands are dropped
// - save word b bit layout as listed
// - config a bit10 reverse, bit9 forward
// - config bit4 drive or brake mode
// - config bit3 free run or auto regen
// - config bits2:1 speed reset timeout
// - config bit0 enables other config bits
// - config b write one clears bit
// - config b bit8 comp, bit7 pin off
// - config b bits2:1 baud, 00 default
// - address bit7, two 7-bit data, sum check
`timescale 1ns/1ps
`include "mcr_defines.svh"
module mcr_regs
    import mcr_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [6:0] unit_addr_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic reverse_pin_level_i,
    input wire logic forward_pin_level_i,
    input wire logic brake_pin_level_i,
    input wire logic overheat_flag_i,
    input wire logic supply_high_flag_i,
    input wire logic supply_low_flag_i,
    input wire logic braking_now_i,
    input wire logic reverse_active_i,
    input wire logic forward_active_i,
    input wire logic [13:0] saved_mask_a_i,
    input wire logic [13:0] saved_cfg_b_i,
    input wire logic flash_done_i,
    output logic tx_valid_o,
    output logic [7:0] tx_byte_o,
    output logic [13:0] speed_o,
    output logic speed_wr_o,
    output logic [3:0] pot_ignore_o,
    output logic [13:0] save_select_a_o,
    output logic [13:0] save_select_b_o,
    output logic flash_save_o,
    output logic pwm_halt_o,
    output logic reverse_cmd_o,
    output logic forward_cmd_o,
    output logic operating_choice_o,
    output logic brake_style_select_o,
    output logic serial_override_enable_o,
    output logic top_speed_comp_o,
    output logic pin_brake_off_o,
    output logic [1:0] serial_baud_select_o
);
    ////////////////////////////////////////////////////////////////////////
    // registers and frame state
    mcr_state_type state; // frame decoder state
    logic [6:0] cmd; // captured command byte
    logic [6:0] data_hi; // first data byte
    logic [6:0] data_lo; // second data byte
    logic [13:0] drive_status; // live status word
    logic [13:0] pot_lock_mask; // pot lock bits
    logic [13:0] save_select_a; // first save selection
    logic [13:0] save_trigger_b; // second save selection
    logic [13:0] run_config_a; // first config word
    logic [13:0] run_config_b; // second config word
    logic [13:0] rd_word; // word being answered
    logic [31:0] to_cnt; // speed timeout counter
    logic [31:0] to_limit; // selected timeout length
    logic saving; // flash save in progress
    logic [15:0] save_cnt; // save duration counter
    logic [13:0] wr_word; // assembled write data
    logic chk_ok; // check byte matches
    logic is_read; // command is a read
    logic [13:0] rd_mux; // read data select
    logic [6:0] tx_sum; // answer check byte
    logic [13:0] reload_lock; // locks implied by saved items
    logic [13:0] save_lock; // locks set by a save start
    logic chk_due; // check byte owed on the next cycle

    assign wr_word = {data_hi, data_lo}; // high byte first
    assign chk_ok = rx_byte_i[6:0] == 7'(cmd + data_hi + data_lo);
    assign is_read = cmd[6:4] == 3'h3;
    assign tx_sum = 7'(cmd + rd_word[13:7] + rd_word[6:0]);
    // save bits speed 0, current 2, regen 3, accel 4 land on
    // lock bits 3, 2, 1, 0: the two layouts run in opposite order
    assign reload_lock = {10'h000, saved_mask_a_i[0], saved_mask_a_i[2],
                          saved_mask_a_i[3], saved_mask_a_i[4]};
    // items marked for saving lock as soon as the save is started,
    // not only after the next restart reloads them
    assign save_lock = {10'h000, save_select_a[0], save_select_a[2],
                        save_select_a[3], save_select_a[4]};

    ////////////////////////////////////////////////////////////////////////
    // read data select
    always_comb begin
        unique case (cmd)
            `MCR_RD_STATUS: rd_mux = drive_status;
            `MCR_RD_LOCK: rd_mux = pot_lock_mask;
            `MCR_RD_SAVE_A: rd_mux = save_select_a;
            `MCR_RD_SAVE_B: rd_mux = save_trigger_b;
            `MCR_RD_CFG_A: rd_mux = run_config_a;
            `MCR_RD_CFG_B: rd_mux = run_config_b;
            default: rd_mux = `MCR_ZERO14; // unmapped reads answer zero
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // live status word, resampled every cycle so reads see present state
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drive_status <= `MCR_ZERO14;
        end else begin
            drive_status <= `MCR_ZERO14;
            drive_status[`MCR_ST_REV] <= reverse_active_i;
            drive_status[`MCR_ST_FWD] <= forward_active_i;
            drive_status[`MCR_ST_REVERSE_PIN_LEVEL] <= reverse_pin_level_i;
            drive_status[`MCR_ST_FORWARD_PIN_LEVEL] <= forward_pin_level_i;
            drive_status[`MCR_ST_BPIN] <= brake_pin_level_i;
            drive_status[`MCR_ST_DT] <= braking_now_i;
            drive_status[`MCR_ST_OT] <= overheat_flag_i;
            drive_status[`MCR_ST_OV] <= supply_high_flag_i;
            drive_status[`MCR_ST_UV] <= supply_low_flag_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame decoder: address, command, two data bytes, check byte
    // a byte with bit 7 set mid-frame sends the decoder back to idle but is not
    // taken as an address, so a lost byte can also cost the frame that follows
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= MCR_IDLE;
            cmd <= 7'h00;
            data_hi <= 7'h00;
            data_lo <= 7'h00;
            rd_word <= `MCR_ZERO14;
        end else if (saving) begin
            state <= MCR_IDLE;
        end else begin
            unique case (state)
                MCR_IDLE: begin
                    if (rx_valid_i && rx_byte_i ==
                        (`MCR_ADDR_FLAG | {1'b0, unit_addr_i})) begin
                        state <= MCR_CMD;
                    end
                end
                MCR_CMD: begin
                    if (rx_valid_i) begin
                        cmd <= rx_byte_i[6:0];
                        if (rx_byte_i[7]) begin
                            state <= MCR_IDLE; // framing error
                        end else if (rx_byte_i[6:4] == 3'h3) begin
                            rd_word <= `MCR_ZERO14;
                            state <= MCR_TX1; // reads need no data
                        end else begin
                            state <= MCR_D1;
                        end
                    end
                end
                MCR_D1: begin
                    if (rx_valid_i) begin
                        data_hi <= rx_byte_i[6:0];
                        state <= rx_byte_i[7] ? MCR_IDLE : MCR_D2;
                    end
                end
                MCR_D2: begin
                    if (rx_valid_i) begin
                        data_lo <= rx_byte_i[6:0];
                        state <= rx_byte_i[7] ? MCR_IDLE : MCR_CHK;
                    end
                end
                MCR_CHK: begin
                    if (rx_valid_i) begin
                        state <= MCR_IDLE; // write applied below
                    end
                end
                MCR_TX1: begin
                    rd_word <= rd_mux;
                    state <= MCR_TX2;
                end
                MCR_TX2: begin
                    state <= MCR_TX3;
                end
                MCR_TX3: begin
                    state <= MCR_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answer bytes: high data, low data, check
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_valid_o <= 1'b0;
            tx_byte_o <= 8'h00;
            chk_due <= 1'b0;
        end else begin
            tx_valid_o <= 1'b0;
            // a flag, not a byte compare, so the check byte goes out
            // exactly once even when it happens to equal the low byte
            chk_due <= !saving && state == MCR_TX3;
            if (!saving && state == MCR_TX2) begin
                tx_valid_o <= 1'b1;
                tx_byte_o <= {1'b0, rd_word[13:7]};
            end else if (!saving && state == MCR_TX3) begin
                tx_valid_o <= 1'b1;
                tx_byte_o <= {1'b0, rd_word[6:0]};
            end else if (chk_due) begin
                tx_valid_o <= 1'b1;
                tx_byte_o <= {1'b0, tx_sum} & `MCR_LOW7;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // writable registers, applied on a frame with a good check byte
    logic wr_go; // accepted write strobe
    assign wr_go = !saving && state == MCR_CHK && rx_valid_i &&
                   !rx_byte_i[7] && chk_ok && !is_read;

    // lock mask, empty after restart unless saved items relock
    logic reload_done; // reload applied once after release
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pot_lock_mask <= `MCR_ZERO14;
            reload_done <= 1'b0;
        end else if (!reload_done) begin
            pot_lock_mask <= reload_lock;
            reload_done <= 1'b1;
        end else if (wr_go && cmd == `MCR_WR_LOCK) begin
            pot_lock_mask <= wr_word & `MCR_LOCK_MASK;
        end else if (wr_go && cmd == `MCR_WR_SAVE_B) begin
            pot_lock_mask <= pot_lock_mask | save_lock;
        end
    end

    // save selections; word a never starts a flash write
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            save_select_a <= `MCR_ZERO14;
            save_trigger_b <= `MCR_ZERO14;
        end else if (wr_go && cmd == `MCR_WR_SAVE_A) begin
            save_select_a <= wr_word & `MCR_SAVE_A_MASK;
        end else if (wr_go && cmd == `MCR_WR_SAVE_B) begin
            save_trigger_b <= wr_word & `MCR_SAVE_B_MASK;
        end
    end

    // flash save: pwm stops and commands are not taken until done
    // the controller cannot police wear; hosts must pace triggers
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            saving <= 1'b0;
            save_cnt <= 16'h0000;
            flash_save_o <= 1'b0;
        end else begin
            flash_save_o <= 1'b0;
            if (wr_go && cmd == `MCR_WR_SAVE_B) begin
                saving <= 1'b1;
                flash_save_o <= 1'b1;
                save_cnt <= 16'h0000;
            end else if (saving) begin
                save_cnt <= save_cnt + 16'h0001;
                if (flash_done_i ||
                    save_cnt == 16'(`MCR_FLASH_CYC)) begin
                    saving <= 1'b0;
                end
            end
        end
    end

    // config word a, all fields cleared on restart
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_config_a <= `MCR_ZERO14;
        end else if (wr_go && cmd == `MCR_WR_CFG_A) begin
            run_config_a <= wr_word & `MCR_CFG_A_MASK;
        end
    end

    // config word b: reload once, then writing ones clears bits
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_config_b <= `MCR_ZERO14;
        end else if (!reload_done) begin
            run_config_b <= saved_cfg_b_i & `MCR_CFG_B_MASK;
        end else if (wr_go && cmd == `MCR_WR_CFG_B) begin
            run_config_b <= run_config_b & ~wr_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // speed register with timeout; timer restarts on each speed write
    always_comb begin
        unique case (run_config_a[`MCR_CA_SRC_HI:`MCR_CA_SRC_LO])
            2'b01: to_limit = `MCR_TO1_CYC;
            2'b10: to_limit = `MCR_TO2_CYC;
            2'b11: to_limit = `MCR_TO3_CYC;
            2'b00: to_limit = 32'h00000000; // never times out
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            speed_o <= `MCR_ZERO14;
            speed_wr_o <= 1'b0;
            to_cnt <= 32'h00000000;
        end else begin
            speed_wr_o <= 1'b0;
            if (wr_go && cmd == `MCR_WR_SPEED) begin
                speed_o <= wr_word;
                speed_wr_o <= 1'b1;
                to_cnt <= 32'h00000000;
            end else if (run_config_a[`MCR_CA_UC] &&
                         to_limit != 32'h00000000) begin
                if (to_cnt >= to_limit - 32'h00000001) begin
                    speed_o <= `MCR_ZERO14;
                end else begin
                    to_cnt <= to_cnt + 32'h00000001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control outputs, gated by serial override where it applies
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pot_ignore_o <= 4'h0;
            save_select_a_o <= `MCR_ZERO14;
            save_select_b_o <= `MCR_ZERO14;
            pwm_halt_o <= 1'b0;
            reverse_cmd_o <= 1'b0;
            forward_cmd_o <= 1'b0;
            operating_choice_o <= 1'b0;
            brake_style_select_o <= 1'b0;
            serial_override_enable_o <= 1'b0;
            top_speed_comp_o <= 1'b0;
            pin_brake_off_o <= 1'b0;
            serial_baud_select_o <= 2'b00;
        end else begin
            pot_ignore_o <= pot_lock_mask[3:0];
            save_select_a_o <= save_select_a;
            save_select_b_o <= save_trigger_b;
            pwm_halt_o <= saving;
            serial_override_enable_o <= run_config_a[`MCR_CA_UC];
            reverse_cmd_o <= run_config_a[`MCR_CA_UC] &
                             run_config_a[`MCR_CA_REV];
            forward_cmd_o <= run_config_a[`MCR_CA_UC] &
                             run_config_a[`MCR_CA_FWD];
            operating_choice_o <= run_config_a[`MCR_CA_UC] &
                                  run_config_a[`MCR_CA_DM];
            brake_style_select_o <= run_config_a[`MCR_CA_UC] &
                                    run_config_a[`MCR_CA_BM];
            top_speed_comp_o <= run_config_b[8];
            pin_brake_off_o <= run_config_b[7];
            serial_baud_select_o <= run_config_b[2:1];
        end
    end
endmodule

// File: mcr_host.sv
// host model that frames serial commands and gathers the answers
`timescale 1ns/1ps
module mcr_host (
    input wire logic ref_clk_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_byte_i,
    output logic rx_valid_o,
    output logic [7:0] rx_byte_o
);
    logic [6:0] ans [3]; // answer bytes, hi, lo, check
    // idle line at start
    initial begin
        rx_valid_o = 1'b0;
        rx_byte_o = 8'h00;
    end
    // one frame; bump spoils the check byte on purpose
    task automatic xfer(input logic [6:0] addr, input logic [6:0] cmd,
        input logic [13:0] data, input logic wr, input logic [6:0] bump,
        output logic [13:0] rd, output logic ok);
        logic [7:0] b [5];
        int k;
        b[0] = {1'b1, addr};
        b[1] = {1'b0, cmd};
        b[2] = {1'b0, data[13:7]};
        b[3] = {1'b0, data[6:0]};
        b[4] = {1'b0, 7'(cmd + data[13:7] + data[6:0] + bump)};
        k = 0;
        for (int i = 0; i < (wr ? 5 : 2); i++) begin
            @(posedge ref_clk_i) #1;
            rx_valid_o = 1'b1;
            rx_byte_o = b[i];
        end
        // released line shows the inverse, never a stale byte
        repeat (12) begin
            @(posedge ref_clk_i) #1;
            if (rx_valid_o) begin
                rx_byte_o = ~rx_byte_o;
            end
            rx_valid_o = 1'b0;
            if (tx_valid_i === 1'b1 && k < 3) begin
                ans[k] = tx_byte_i[6:0];
                k++;
            end
        end
        rd = {ans[0], ans[1]};
        ok = (k == 3) && (ans[2] === 7'(cmd + ans[0] + ans[1]));
    endtask
endmodule

// File: mcr_regs_chk.sv
// port-level assertions for the register bank
`timescale 1ns/1ps
module mcr_regs_chk (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_byte_o,
    input wire logic speed_wr_o,
    input wire logic [13:0] save_select_a_o,
    input wire logic flash_save_o,
    input wire logic pwm_halt_o,
    input wire logic reverse_cmd_o,
    input wire logic forward_cmd_o,
    input wire logic operating_choice_o,
    input wire logic brake_style_select_o,
    input wire logic serial_override_enable_o,
    input wire logic top_speed_comp_o,
    input wire logic pin_brake_off_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [10:0] halt_len; // cycles spent halted
    // a counter, since a long repetition would choke the tools
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            halt_len <= 11'h000;
        end else if (pwm_halt_o) begin
            halt_len <= halt_len + 11'h001;
        end else begin
            halt_len <= 11'h000;
        end
    end
    // three answer bytes back to back
    sequence s_answer;
        tx_valid_o [*3] ##1 !tx_valid_o;
    endsequence
    // save pulse then halt
    sequence s_save_start;
        flash_save_o ##1 (pwm_halt_o && !flash_save_o);
    endsequence
    a_answer_three: assert property ($rose(tx_valid_o) |-> s_answer)
        else $error("answer is not three bytes");
    a_answer_bit7: assert property (tx_valid_o |-> !tx_byte_o[7])
        else $error("answer byte has top bit set");
    a_save_halts: assert property (flash_save_o |-> s_save_start)
        else $error("save start did not halt");
    a_save_bounded: assert property (halt_len <= 11'h3EB)
        else $error("save halt too long");
    a_halt_stalls: assert property (pwm_halt_o && $past(pwm_halt_o)
        |-> $stable(save_select_a_o) && !speed_wr_o)
        else $error("register changed during save");
    a_fwd_gated: assert property (forward_cmd_o |-> serial_override_enable_o)
        else $error("forward without override");
    a_rev_gated: assert property (reverse_cmd_o |-> serial_override_enable_o)
        else $error("reverse without override");
    a_mode_gated: assert property ((operating_choice_o || brake_style_select_o)
        |-> serial_override_enable_o)
        else $error("mode bits without override");
    a_cfgb_no_set: assert property ($past(reset_n_i, 4)
        |-> !$rose(top_speed_comp_o) && !$rose(pin_brake_off_o))
        else $error("config b bit was set by traffic");
endmodule
bind mcr_regs mcr_regs_chk mcr_regs_chk_inst (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .tx_valid_o(tx_valid_o),
    .tx_byte_o(tx_byte_o), .speed_wr_o(speed_wr_o),
    .save_select_a_o(save_select_a_o), .flash_save_o(flash_save_o),
    .pwm_halt_o(pwm_halt_o), .reverse_cmd_o(reverse_cmd_o),
    .forward_cmd_o(forward_cmd_o), .operating_choice_o(operating_choice_o),
    .brake_style_select_o(brake_style_select_o),
    .serial_override_enable_o(serial_override_enable_o),
    .top_speed_comp_o(top_speed_comp_o), .pin_brake_off_o(pin_brake_off_o));

// File: tb_top.sv
// self-checking bench for the motor controller register bank
`timescale 1ns/1ps
module tb_top;
    localparam logic [6:0] ADDR = 7'h05; // our unit address
    typedef struct {
        logic [6:0] wc;
        logic [13:0] d;
        logic [6:0] rc;
        logic [13:0] e;
    } mcr_row_type;
    logic ref_clk_i, reset_n_i, rx_valid_i, tx_valid_o, speed_wr_o;
    logic rev_pin, fwd_pin, brk_pin, hot, sup_hi, sup_lo, braking;
    logic rev_act, fwd_act, flash_save_o, pwm_halt_o, ov_en;
    logic rev_cmd, fwd_cmd, op_choice, brk_style, top_comp, pin_off;
    logic [7:0] rx_byte_i, tx_byte_o;
    logic [13:0] saved_mask_a_i, saved_cfg_b_i, cmd_view, cfgb_view, speed;
    logic [3:0] pot_ignore_o;
    logic [1:0] baud;
    int err_count = 0, checks = 0, save_pulses = 0, n;
    mcr_row_type rows [5] = '{'{7'h71, 14'h3FFF, 7'h31, 14'h000F},
        '{7'h71, 14'h0000, 7'h31, 14'h0000},
        '{7'h72, 14'h3FFF, 7'h32, 14'h3BFD},
        '{7'h74, 14'h061F, 7'h34, 14'h061F},
        '{7'h74, 14'h3FFE, 7'h34, 14'h061E}};
    assign cmd_view = {9'h000, rev_cmd, fwd_cmd, op_choice, brk_style, ov_en};
    assign cfgb_view = {10'h000, top_comp, pin_off, baud};
    mcr_regs mcr_regs_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .unit_addr_i(ADDR), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
        .reverse_pin_level_i(rev_pin), .forward_pin_level_i(fwd_pin),
        .brake_pin_level_i(brk_pin), .overheat_flag_i(hot),
        .supply_high_flag_i(sup_hi), .supply_low_flag_i(sup_lo),
        .braking_now_i(braking), .reverse_active_i(rev_act),
        .forward_active_i(fwd_act), .saved_mask_a_i(saved_mask_a_i),
        .saved_cfg_b_i(saved_cfg_b_i), .flash_done_i(1'b0),
        .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .speed_o(speed),
        .speed_wr_o(speed_wr_o), .pot_ignore_o(pot_ignore_o),
        .save_select_a_o(), .save_select_b_o(), .flash_save_o(flash_save_o),
        .pwm_halt_o(pwm_halt_o), .reverse_cmd_o(rev_cmd),
        .forward_cmd_o(fwd_cmd), .operating_choice_o(op_choice),
        .brake_style_select_o(brk_style), .serial_override_enable_o(ov_en),
        .top_speed_comp_o(top_comp), .pin_brake_off_o(pin_off),
        .serial_baud_select_o(baud));
    mcr_host mcr_host_inst (.ref_clk_i(ref_clk_i), .tx_valid_i(tx_valid_o),
        .tx_byte_i(tx_byte_o), .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i));
    // clock, 10 ns period
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // count save starts
    always @(posedge ref_clk_i) begin
        if (flash_save_o === 1'b1) begin
            save_pulses++;
        end
    end
    task automatic chk_word(input logic [13:0] got, input logic [13:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrx(input logic [6:0] a, input logic [6:0] c,
        input logic [13:0] d, input logic [6:0] bump);
        logic [13:0] v;
        logic ok;
        mcr_host_inst.xfer(a, c, d, 1'b1, bump, v, ok);
    endtask
    task automatic wr(input logic [6:0] c, input logic [13:0] d);
        wrx(ADDR, c, d, 7'h00);
    endtask
    task automatic rdchk(input logic [6:0] c, input logic [13:0] e);
        logic [13:0] v;
        logic ok;
        mcr_host_inst.xfer(ADDR, c, 14'h0000, 1'b0, 7'h00, v, ok);
        chk_bit(ok, 1'b1);
        chk_word(v, e);
    endtask
    // reset held three cycles, released off the edge
    task automatic do_reset();
        reset_n_i = 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #1 reset_n_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
    endtask
    task automatic end_sim();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog, about ten times the expected run
    initial begin
        #200000;
        err_count++;
        end_sim();
    end
    initial begin
        {rev_pin, fwd_pin, brk_pin, hot, sup_hi, sup_lo} = 6'h00;
        {braking, rev_act, fwd_act} = 3'h0;
        saved_mask_a_i = 14'h0000;
        saved_cfg_b_i = 14'h01C6;
        do_reset();
        rdchk(7'h35, 14'h01C6);
        chk_word(cfgb_view, 14'h000F);
        wr(7'h75, 14'h0100);
        rdchk(7'h35, 14'h00C6);
        chk_word(cfgb_view, 14'h0007);
        wr(7'h75, 14'h0000);
        rdchk(7'h35, 14'h00C6);
        foreach (rows[i]) begin
            wr(rows[i].wc, rows[i].d);
            rdchk(rows[i].rc, rows[i].e);
        end
        chk_word(14'(save_pulses), 14'h0000);
        wr(7'h74, 14'h061B);
        chk_word(cmd_view, 14'h001F);
        wr(7'h74, 14'h061A);
        chk_word(cmd_view, 14'h0000);
        {rev_act, brk_pin, hot, sup_lo, braking} = 5'h1F;
        rdchk(7'h30, 14'h0455);
        {rev_act, brk_pin, hot, sup_lo, braking} = 5'h00;
        {fwd_act, rev_pin, fwd_pin, sup_hi} = 4'hF;
        rdchk(7'h30, 14'h0382);
        wr(7'h71, 14'h000F);
        chk_word({10'h000, pot_ignore_o}, 14'h000F);
        wr(7'h71, 14'h0000);
        wrx(7'h06, 7'h71, 14'h000F, 7'h00);
        rdchk(7'h31, 14'h0000);
        wrx(ADDR, 7'h71, 14'h000F, 7'h01);
        rdchk(7'h31, 14'h0000);
        rdchk(7'h3C, 14'h0000);
        wr(7'h40, 14'h05C5);
        chk_word(speed, 14'h05C5);
        // a single save only, flash wears out
        wr(7'h73, 14'h001F);
        chk_bit(pwm_halt_o, 1'b1);
        chk_word(14'(save_pulses), 14'h0001);
        wr(7'h71, 14'h0000);
        for (n = 0; n < 1100 && pwm_halt_o !== 1'b0; n++) begin
            @(posedge ref_clk_i) #1;
        end
        chk_bit(pwm_halt_o, 1'b0);
        rdchk(7'h31, 14'h000F);
        rdchk(7'h33, 14'h001F);
        saved_mask_a_i = 14'h0001;
        do_reset();
        rdchk(7'h31, 14'h0008);
        saved_mask_a_i = 14'h0000;
        saved_cfg_b_i = 14'h0000;
        do_reset();
        rdchk(7'h31, 14'h0000);
        rdchk(7'h34, 14'h0000);
        chk_word(cfgb_view, 14'h0000);
        end_sim();
    end
endmodule
